// [hdl/wcce_map.svh]
// register offsets, field positions, reset values and opcodes of the executor
`ifndef WCCE_MAP_SVH
`define WCCE_MAP_SVH

`define WCCE_CTRL_OFS    8'h00
`define WCCE_INSTR_OFS   8'h04
`define WCCE_STATUS_OFS  8'h08
`define WCCE_WREG_OFS    8'h0c
`define WCCE_BANK_OFS    8'h10
`define WCCE_IBASE_OFS   8'h14
`define WCCE_MADDR_OFS   8'h18
`define WCCE_MDATA_OFS   8'h1c
`define WCCE_WDTCNT_OFS  8'h20
`define WCCE_WDTPS_OFS   8'h24

`define WCCE_CTRL_EXT    0
`define WCCE_CTRL_SLEEP  1
`define WCCE_CTRL_WDTEN  2

`define WCCE_ST_Z        0
`define WCCE_ST_N        1
`define WCCE_ST_PWD      2
`define WCCE_ST_TMO      3
`define WCCE_ST_BUSY     4
`define WCCE_ST_BADOP    5

`define WCCE_CTRL_RST    3'h0
`define WCCE_WDCLR_WORD  16'h0004
`define WCCE_CPL_PFX     6'h07
`define WCCE_ILO_MAX     8'h5f
`define WCCE_WDT_PERIOD  256
`define WCCE_WDT_POST    128

`endif

// [hdl/wcce_pkg.sv]
// types shared by the instruction executor
package wcce_pkg;

  typedef enum logic [1:0] {
    WCCE_OP_NONE,
    WCCE_OP_WDCLR,
    WCCE_OP_CPL
  } wcce_op_t;

  typedef struct packed {
    wcce_op_t   op;
    logic       dest;
    logic       acc;
    logic [7:0] faddr;
  } wcce_dec_t;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic neg;
    logic zero;
  } wcce_stat_t;

endpackage : wcce_pkg

// [hdl/wcce_top.sv]
// watchdog-clear and byte-complement executor with an AHB-Lite register slave
//
// Contract
// - the watchdog clear zeroes the watchdog counter and its postscaler.
// - the complement reads the addressed byte and yields its bitwise inversion.
// - destination bit 0 sends the result to W, 1 writes it back to the source byte.
// - access bit 0 addresses the operand through the access bank.
// - access bit 1 forms the address from the bank select register and the field.
// - extended set on, access bit 0 and field at most 95 select indexed literal offset.
`timescale 1ns/1ns
`include "wcce_map.svh"

module wcce_top #(
  parameter int WDT_PERIOD = `WCCE_WDT_PERIOD,
  parameter int WDT_POST   = `WCCE_WDT_POST
) (
  input  wire logic        sys_clk,        // core clock
  input  wire logic        rst_n,          // async reset, active low
  input  wire logic        hsel,           // slave select
  input  wire logic [31:0] haddr,          // byte address
  input  wire logic [1:0]  htrans,         // transfer type
  input  wire logic        hwrite,         // write when high
  input  wire logic [2:0]  hsize,          // transfer size
  input  wire logic [31:0] hwdata,         // write data
  input  wire logic        hready,         // bus ready
  output logic             hreadyout,      // slave ready
  output logic [31:0]      hrdata,         // read data
  output logic             hresp,          // response, always okay
  output logic             timeout_flag,   // low after watchdog expiry
  output logic             powerdown_flag, // low after sleep request
  output logic             busy            // instruction in flight
);
  import wcce_pkg::*;

  typedef enum {QS_IDLE, QS_Q1, QS_Q2, QS_Q3, QS_Q4} wcce_q_t;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [11:0] wcce_ea(
    input logic [7:0]  f,
    input logic        acc,
    input logic        ext,
    input logic [3:0]  bank,
    input logic [11:0] ibase
  );
    logic [11:0] ea;
    ea = {bank, f};
    if (!acc && ext && (f <= `WCCE_ILO_MAX)) begin
      ea = ibase + {4'h0, f};
    end else if (!acc) begin
      ea = f[7] ? {4'hf, f} : {4'h0, f};
    end
    return ea;
  endfunction : wcce_ea

  function automatic wcce_dec_t wcce_decode(input logic [15:0] iw);
    wcce_dec_t d;
    d.op    = WCCE_OP_NONE;
    d.dest  = iw[9];
    d.acc   = iw[8];
    d.faddr = iw[7:0];
    if (iw == `WCCE_WDCLR_WORD) begin
      d.op = WCCE_OP_WDCLR;
    end else if (iw[15:10] == `WCCE_CPL_PFX) begin
      d.op = WCCE_OP_CPL;
    end
    return d;
  endfunction : wcce_decode

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [7:0]  mem [0:4095];
  logic [2:0]  ctrl_reg;
  logic [15:0] instr_reg;
  wcce_dec_t   dec_reg;
  wcce_dec_t   dec_next;
  wcce_q_t     q_reg;
  wcce_stat_t  stat_now;
  logic        badop_reg;
  logic [7:0]  w_reg;
  logic        neg_reg;
  logic        zero_reg;
  logic [3:0]  bank_reg;
  logic [11:0] ibase_reg;
  logic [11:0] maddr_reg;
  logic [11:0] ea_reg;
  logic [7:0]  opnd_reg;
  logic [7:0]  res_reg;
  logic [15:0] wdt_cnt_reg;
  logic [15:0] wdt_ps_reg;
  logic        wd_clear;
  logic [7:0]  ph_addr_reg;
  logic        ph_wr_reg;
  logic        ph_rd_val;
  logic        wr_en;
  logic [31:0] rd_next;
  logic        addr_ok;
  logic        wdt_expire;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  assign addr_ok = hsel && htrans[1] && hready;
  assign wr_en   = ph_wr_reg;
  assign ph_rd_val = addr_ok && !hwrite;
  assign dec_next  = wcce_decode(instr_reg);
  assign wd_clear  = (q_reg == QS_Q3) && (dec_reg.op == WCCE_OP_WDCLR);
  assign stat_now  = '{timeout_flag, powerdown_flag, neg_reg, zero_reg};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_addr_reg <= 8'h00;
      ph_wr_reg   <= 1'b0;
    end else begin
      ph_wr_reg <= addr_ok && hwrite;
      if (addr_ok) begin
        ph_addr_reg <= haddr[7:0];
      end
    end
  end

  always_comb begin
    rd_next = 32'h0000_0000;
    case ({haddr[7:2], 2'b00})
      `WCCE_CTRL_OFS:   rd_next = {29'h0, ctrl_reg};
      `WCCE_INSTR_OFS:  rd_next = {16'h0, instr_reg};
      `WCCE_STATUS_OFS: begin
        rd_next[`WCCE_ST_Z]     = stat_now.zero;
        rd_next[`WCCE_ST_N]     = stat_now.neg;
        rd_next[`WCCE_ST_PWD]   = stat_now.powerdown_flag;
        rd_next[`WCCE_ST_TMO]   = stat_now.timeout_flag;
        rd_next[`WCCE_ST_BUSY]  = (q_reg != QS_IDLE);
        rd_next[`WCCE_ST_BADOP] = badop_reg;
      end
      `WCCE_WREG_OFS:   rd_next = {24'h0, w_reg};
      `WCCE_BANK_OFS:   rd_next = {28'h0, bank_reg};
      `WCCE_IBASE_OFS:  rd_next = {20'h0, ibase_reg};
      `WCCE_MADDR_OFS:  rd_next = {20'h0, maddr_reg};
      `WCCE_MDATA_OFS:  rd_next = {24'h0, mem[maddr_reg]};
      `WCCE_WDTCNT_OFS: rd_next = {16'h0, wdt_cnt_reg};
      `WCCE_WDTPS_OFS:  rd_next = {16'h0, wdt_ps_reg};
      default:          rd_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ph_rd_val) begin
        hrdata <= rd_next;
      end
    end
  end

  // ------------------------------------------------------------
  // software registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg  <= `WCCE_CTRL_RST;
      bank_reg  <= 4'h0;
      ibase_reg <= 12'h000;
      maddr_reg <= 12'h000;
    end else if (wr_en) begin
      case (ph_addr_reg & 8'hfc)
        `WCCE_CTRL_OFS:  ctrl_reg  <= {hwdata[2], 1'b0, hwdata[0]};
        `WCCE_BANK_OFS:  bank_reg  <= hwdata[3:0];
        `WCCE_IBASE_OFS: ibase_reg <= hwdata[11:0];
        `WCCE_MADDR_OFS: maddr_reg <= hwdata[11:0];
        default: begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // four-phase sequencer
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg     <= QS_IDLE;
      instr_reg <= 16'h0000;
      dec_reg   <= '0;
      badop_reg <= 1'b0;
      busy      <= 1'b0;
    end else begin
      case (q_reg)
        QS_IDLE: begin
          // a new word is taken only between instructions
          if (wr_en && ((ph_addr_reg & 8'hfc) == `WCCE_INSTR_OFS)) begin
            instr_reg <= hwdata[15:0];
            q_reg     <= QS_Q1;
            busy      <= 1'b1;
          end
        end
        QS_Q1: begin
          dec_reg   <= dec_next;
          badop_reg <= (dec_next.op == WCCE_OP_NONE);
          q_reg     <= QS_Q2;
        end
        QS_Q2: q_reg <= QS_Q3;
        QS_Q3: q_reg <= QS_Q4;
        QS_Q4: begin
          q_reg <= QS_IDLE;
          busy  <= 1'b0;
        end
        default: begin
          q_reg <= QS_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // operand read and processing
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ea_reg   <= 12'h000;
      opnd_reg <= 8'h00;
      res_reg  <= 8'h00;
    end else begin
      if (q_reg == QS_Q1) begin
        ea_reg <= wcce_ea(instr_reg[7:0], instr_reg[8], ctrl_reg[`WCCE_CTRL_EXT],
                          bank_reg, ibase_reg);
      end
      if (q_reg == QS_Q2) begin
        opnd_reg <= mem[ea_reg];
      end
      if (q_reg == QS_Q3) begin
        res_reg <= ~opnd_reg;
      end
    end
  end

  // data memory: instruction write-back has the port; software writes outside idle are dropped
  always_ff @(posedge sys_clk) begin
    if (q_reg == QS_Q4 && dec_reg.op == WCCE_OP_CPL && dec_reg.dest) begin
      mem[ea_reg] <= res_reg;
    end else if (wr_en && q_reg == QS_IDLE &&
                 ((ph_addr_reg & 8'hfc) == `WCCE_MDATA_OFS)) begin
      mem[maddr_reg] <= hwdata[7:0];
    end
  end

  // ------------------------------------------------------------
  // working register and arithmetic flags
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      w_reg    <= 8'h00;
      neg_reg  <= 1'b0;
      zero_reg <= 1'b0;
    end else if (q_reg == QS_Q4 && dec_reg.op == WCCE_OP_CPL) begin
      if (!dec_reg.dest) begin
        w_reg <= res_reg;
      end
      neg_reg  <= res_reg[7];
      zero_reg <= (res_reg == 8'h00);
    end else if (wr_en && q_reg == QS_IDLE) begin
      if ((ph_addr_reg & 8'hfc) == `WCCE_WREG_OFS) begin
        w_reg <= hwdata[7:0];
      end
      if ((ph_addr_reg & 8'hfc) == `WCCE_STATUS_OFS) begin
        neg_reg  <= hwdata[`WCCE_ST_N];
        zero_reg <= hwdata[`WCCE_ST_Z];
      end
    end
  end

  // ------------------------------------------------------------
  // watchdog counter and postscaler
  // ------------------------------------------------------------
  assign wdt_expire = ctrl_reg[`WCCE_CTRL_WDTEN] &&
                      (wdt_cnt_reg == 16'(WDT_PERIOD - 1)) &&
                      (wdt_ps_reg == 16'(WDT_POST - 1));

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_cnt_reg <= 16'h0000;
      wdt_ps_reg  <= 16'h0000;
    end else if (wd_clear) begin
      wdt_cnt_reg <= 16'h0000;
      wdt_ps_reg  <= 16'h0000;
    end else if (ctrl_reg[`WCCE_CTRL_WDTEN]) begin
      if (wdt_cnt_reg == 16'(WDT_PERIOD - 1)) begin
        wdt_cnt_reg <= 16'h0000;
        wdt_ps_reg  <= (wdt_ps_reg == 16'(WDT_POST - 1)) ? 16'h0000 : wdt_ps_reg + 16'h0001;
      end else begin
        wdt_cnt_reg <= wdt_cnt_reg + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // time-out and power-down flags
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end else begin
      // expiry and sleep requests win over a coincident watchdog clear
      if (wdt_expire) begin
        timeout_flag <= 1'b0;
      end else if (wd_clear) begin
        timeout_flag <= 1'b1;
      end
      if (wr_en && ((ph_addr_reg & 8'hfc) == `WCCE_CTRL_OFS) && hwdata[`WCCE_CTRL_SLEEP]) begin
        powerdown_flag <= 1'b0;
      end else if (wd_clear) begin
        powerdown_flag <= 1'b1;
      end
    end
  end

endmodule : wcce_top

// [test/testbench.sv]
// self-checking bench for the executor
`timescale 1ns/1ns
`include "wcce_map.svh"

module testbench;
  logic        sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, lfsr = 32'hb5ca, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, timeout_flag, powerdown_flag, busy, d, a, ext;
  logic [31:0] hrdata;
  logic [7:0]  f, dat, w0, res;
  logic [3:0]  b;
  logic [11:0] f2, ad;
  int          num_errors = 0, checks = 0, cyc = 0;

  always #20 sys_clk = ~sys_clk;

  wcce_top #(.WDT_PERIOD(4), .WDT_POST(2)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .timeout_flag(timeout_flag),
    .powerdown_flag(powerdown_flag), .busy(busy));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function logic [31:0] rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : rnd
  function logic [11:0] eaddr(input logic x, input logic ac, input logic [7:0] fa,
                              input logic [3:0] bk, input logic [11:0] ix);
    if (x && !ac && fa <= 8'h5f) return ix + {4'h0, fa};
    if (!ac) return fa[7] ? {4'hf, fa} : {4'h0, fa};
    return {bk, fa};
  endfunction : eaddr
  task check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task ahb(input logic w, input logic [7:0] ofs, input logic [31:0] wd);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, ofs}; hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task exec(input logic [15:0] op);
    int n;
    ahb(1'b1, `WCCE_INSTR_OFS, {16'h0, op});
    n = 0;
    do begin @(posedge sys_clk); n++; end while (busy !== 1'b0 && n < 20);
    check(n, 32'd5);
  endtask : exec
  task close_out;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin num_errors++; close_out(); end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    check({29'h0, timeout_flag, powerdown_flag, busy}, 32'h6);
    ahb(1'b0, `WCCE_STATUS_OFS, 32'h0);
    check({29'h0, rd[4:2]}, 32'h3);
    ahb(1'b0, 8'hfc, 32'h0);
    check(rd, 32'h0);
    $display("test reset done");
    ahb(1'b1, `WCCE_CTRL_OFS, 32'h6);
    repeat (20) @(posedge sys_clk);
    check({30'h0, timeout_flag, powerdown_flag}, 32'h0);
    ahb(1'b1, `WCCE_CTRL_OFS, 32'h0);
    ahb(1'b1, `WCCE_STATUS_OFS, 32'h1);
    exec(`WCCE_WDCLR_WORD);
    check({30'h0, timeout_flag, powerdown_flag}, 32'h3);
    ahb(1'b0, `WCCE_STATUS_OFS, 32'h0);
    check({26'h0, rd[5:0]}, 32'h0d);
    ahb(1'b0, `WCCE_WDTCNT_OFS, 32'h0);
    check(rd, 32'h0);
    ahb(1'b0, `WCCE_WDTPS_OFS, 32'h0);
    check(rd, 32'h0);
    $display("test watchdog clear done");
    for (int i = 0; i < 24; i++) begin
      lfsr = rnd(rnd(rnd(lfsr)));
      {d, a, ext, f, b, f2} = lfsr[26:0];
      dat = (i == 0) ? 8'hff : lfsr[31:24];
      w0 = lfsr[23:16];
      if (i < 3) begin f = 8'h5e + 8'(i); a = 1'b0; ext = 1'b1; end
      ad = eaddr(ext, a, f, b, f2);
      res = ~dat;
      ahb(1'b1, `WCCE_CTRL_OFS, {31'h0, ext});
      ahb(1'b1, `WCCE_BANK_OFS, {28'h0, b});
      ahb(1'b1, `WCCE_IBASE_OFS, {20'h0, f2});
      ahb(1'b1, `WCCE_MADDR_OFS, {20'h0, ad});
      ahb(1'b1, `WCCE_MDATA_OFS, {24'h0, dat});
      ahb(1'b1, `WCCE_WREG_OFS, {24'h0, w0});
      exec({`WCCE_CPL_PFX, d, a, f});
      ahb(1'b0, `WCCE_WREG_OFS, 32'h0);
      check(rd, {24'h0, d ? w0 : res});
      ahb(1'b0, `WCCE_MDATA_OFS, 32'h0);
      check(rd, {24'h0, d ? res : dat});
      ahb(1'b0, `WCCE_STATUS_OFS, 32'h0);
      check({30'h0, rd[1:0]}, {30'h0, res[7], res == 8'h0});
    end
    $display("test complement done");
    exec(16'hffff);
    ahb(1'b0, `WCCE_STATUS_OFS, 32'h0);
    check({31'h0, rd[5]}, 32'h1);
    $display("test unsupported done");
    close_out();
  end
endmodule : testbench

// [test/wcce_top_checker.sv]
// concurrent checks on the executor ports
`timescale 1ns/1ns

module wcce_top_checker (
  input wire logic        sys_clk,        // core clock
  input wire logic        rst_n,          // async reset
  input wire logic        hsel,           // slave select
  input wire logic [31:0] haddr,          // byte address
  input wire logic [1:0]  htrans,         // transfer type
  input wire logic        hwrite,         // write strobe
  input wire logic [31:0] hwdata,         // write data
  input wire logic        hready,         // bus ready
  input wire logic        hreadyout,      // slave ready
  input wire logic [31:0] hrdata,         // read data
  input wire logic        hresp,          // response
  input wire logic        timeout_flag,   // time-out flag
  input wire logic        powerdown_flag, // power-down flag
  input wire logic        busy            // instruction running
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // data phase trackers
  // ----------------------------------------
  logic wr_instr_q;
  logic wr_ctrl_q;
  logic rd_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_instr_q <= 1'b0;
      wr_ctrl_q  <= 1'b0;
      rd_q       <= 1'b0;
    end else begin
      wr_instr_q <= hsel && htrans[1] && hready && hwrite && haddr[7:2] == 6'h01;
      wr_ctrl_q  <= hsel && htrans[1] && hready && hwrite && haddr[7:2] == 6'h00;
      rd_q       <= hsel && htrans[1] && hready && !hwrite;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_clr;
    wr_instr_q && !busy && hwdata[15:0] == 16'h0004;
  endsequence
  sequence s_start;
    wr_instr_q && !busy && (hwdata[15:0] == 16'h0004 || hwdata[15:10] == 6'h07);
  endsequence
  sequence s_four;
    busy[*4] ##1 !busy;
  endsequence
  a_busy_start: assert property (s_start |=> busy)
    else $error("instruction did not start");
  a_busy_four: assert property ($rose(busy) |-> s_four)
    else $error("instruction not four cycles");
  a_clr_flags: assert property (s_clr |-> ##[1:5] (timeout_flag && powerdown_flag))
    else $error("watchdog clear left flags low");
  a_to_cause: assert property ($rose(timeout_flag) |-> busy)
    else $error("time-out flag set outside an instruction");
  a_pd_cause: assert property ($rose(powerdown_flag) |-> busy)
    else $error("power-down flag set outside an instruction");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or error response");
  a_rdata_hold: assert property ($changed(hrdata) |-> rd_q)
    else $error("read data moved without a read");
  a_sleep_pd: assert property (wr_ctrl_q && hwdata[1] |-> ##[1:3] !powerdown_flag)
    else $error("sleep request ignored");
endmodule : wcce_top_checker

bind wcce_top wcce_top_checker i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .timeout_flag(timeout_flag),
  .powerdown_flag(powerdown_flag), .busy(busy));
